// *** hdl/boundary_scan_tap.sv ***
`timescale 1ns/100ps

// Contract
// - Data registers parallel; instruction picks path
// - Boundary chain scanned for EXTEST, SAMPLE/PRELOAD
// - EXTEST at Update-IR drives latches immediately
// - Cell latches update on falling test clock
// - Input cells observe only, no update
// - Bidir capture takes core output when enabled
// - Bidir capture takes pad when disabled/EXTEST
// - Instruction bits shift in on rising edge
// - Instruction latched only at Update-IR
// - Six-bit instruction selects test and path
// - Unselected registers stay undisturbed
// - 000000 is EXTEST, holds latched outputs
// - 000001 is SAMPLE/PRELOAD, no functional effect
// - 000010 is IDCODE, selects identification
// - 000011 is HIGHZ, all outputs float
// - 101101 captured at every Capture-IR
// - 111110 is CLAMP, latches drive pins
// - 111111 is BYPASS, one-bit path
// - CLAMP scans through the bypass bit
// - Bypass captures zero at Capture-DR
// - TAP reset selects IDCODE; ID LSB one
// - TDO on falling edge, driven only shifting
module boundary_scan_tap #(
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter int N_BIDIR = 4,
  parameter logic [10:0] ID_MANUF = 11'h155,  // Arbitrary
  parameter logic [15:0] ID_PART = 16'h1234,  // Arbitrary
  parameter logic [3:0] ID_VER = 4'h1         // Arbitrary
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // Test port pins
  input wire jtag_pkg::tap_pins_s jtag_in,
  output logic tdo_out,
  output logic tdo_oe_out,
  // Core side of output and bidirectional pins
  input wire logic [N_OUT-1:0] core_out_in,
  input wire logic core_oe_in,
  input wire logic [N_BIDIR-1:0] core_bd_out_in,
  input wire logic [N_BIDIR-1:0] core_bd_oe_in,
  // Pad side
  input wire logic [N_IN-1:0] pad_in,
  input wire logic [N_BIDIR-1:0] pad_bd_in,
  output logic [N_OUT-1:0] pad_out,
  output logic pad_oe_out,
  output logic [N_BIDIR-1:0] pad_bd_out,
  output logic [N_BIDIR-1:0] pad_bd_oe_out,
  // Visibility of the active instruction
  output logic [jtag_pkg::IR_W-1:0] ir_out
);

  // Chain order from TDI end: bidir pairs, output enable, outputs, inputs at TDO end
  localparam int O_BASE = N_IN;
  localparam int OE_POS = N_IN + N_OUT;
  localparam int B_BASE = N_IN + N_OUT + 1;
  localparam int BSR_W = B_BASE + 2 * N_BIDIR;
  localparam int SW = 4 + N_IN + N_BIDIR;

  // Every outside level passes three stages and changes once the last two agree
  logic [SW-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic [SW-1:0] raw;
  assign raw = {jtag_in, pad_in, pad_bd_in};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      filt_r <= '0;
    end else if (ce_in) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SW; g++) begin : g_filt
      assign filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
    end
  endgenerate

  wire trst_b_f = filt_r[SW-1];
  wire tck_now = filt_nxt[SW-2];
  wire tck_was = filt_r[SW-2];
  wire tms_f = filt_r[SW-3];
  wire tdi_f = filt_r[SW-4];
  wire [N_IN-1:0] pad_f = filt_r[N_BIDIR +: N_IN];
  wire [N_BIDIR-1:0] pad_bd_f = filt_r[N_BIDIR-1:0];
  wire tck_rise = ce_in & tck_now & ~tck_was;
  wire tck_fall = ce_in & ~tck_now & tck_was;

  // TAP controller
  jtag_pkg::tap_state_e state_r, state_nxt;

  always_comb begin
    unique case (state_r)
      jtag_pkg::TLR: state_nxt = tms_f ? jtag_pkg::TLR : jtag_pkg::RTI;
      jtag_pkg::RTI: state_nxt = tms_f ? jtag_pkg::SEL_DR : jtag_pkg::RTI;
      jtag_pkg::SEL_DR: state_nxt = tms_f ? jtag_pkg::SEL_IR : jtag_pkg::CAP_DR;
      jtag_pkg::CAP_DR: state_nxt = tms_f ? jtag_pkg::EXIT1_DR : jtag_pkg::SHIFT_DR;
      jtag_pkg::SHIFT_DR: state_nxt = tms_f ? jtag_pkg::EXIT1_DR : jtag_pkg::SHIFT_DR;
      jtag_pkg::EXIT1_DR: state_nxt = tms_f ? jtag_pkg::UPD_DR : jtag_pkg::PAUSE_DR;
      jtag_pkg::PAUSE_DR: state_nxt = tms_f ? jtag_pkg::EXIT2_DR : jtag_pkg::PAUSE_DR;
      jtag_pkg::EXIT2_DR: state_nxt = tms_f ? jtag_pkg::UPD_DR : jtag_pkg::SHIFT_DR;
      jtag_pkg::UPD_DR: state_nxt = tms_f ? jtag_pkg::SEL_DR : jtag_pkg::RTI;
      jtag_pkg::SEL_IR: state_nxt = tms_f ? jtag_pkg::TLR : jtag_pkg::CAP_IR;
      jtag_pkg::CAP_IR: state_nxt = tms_f ? jtag_pkg::EXIT1_IR : jtag_pkg::SHIFT_IR;
      jtag_pkg::SHIFT_IR: state_nxt = tms_f ? jtag_pkg::EXIT1_IR : jtag_pkg::SHIFT_IR;
      jtag_pkg::EXIT1_IR: state_nxt = tms_f ? jtag_pkg::UPD_IR : jtag_pkg::PAUSE_IR;
      jtag_pkg::PAUSE_IR: state_nxt = tms_f ? jtag_pkg::EXIT2_IR : jtag_pkg::PAUSE_IR;
      jtag_pkg::EXIT2_IR: state_nxt = tms_f ? jtag_pkg::UPD_IR : jtag_pkg::SHIFT_IR;
      jtag_pkg::UPD_IR: state_nxt = tms_f ? jtag_pkg::SEL_DR : jtag_pkg::RTI;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= jtag_pkg::TLR;
    end else if (ce_in && !trst_b_f) begin
      state_r <= jtag_pkg::TLR;
    end else if (tck_rise) begin
      state_r <= state_nxt;
    end
  end

  wire st_tlr = (state_r == jtag_pkg::TLR);
  wire st_cap_dr = (state_r == jtag_pkg::CAP_DR);
  wire st_sh_dr = (state_r == jtag_pkg::SHIFT_DR);
  wire st_upd_dr = (state_r == jtag_pkg::UPD_DR);
  wire st_cap_ir = (state_r == jtag_pkg::CAP_IR);
  wire st_sh_ir = (state_r == jtag_pkg::SHIFT_IR);
  wire st_upd_ir = (state_r == jtag_pkg::UPD_IR);

  // Instruction register: shift stage and active latch
  logic [jtag_pkg::IR_W-1:0] ir_sh_r, ir_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ir_sh_r <= jtag_pkg::OP_VALIDATE;
    end else if (tck_rise && st_cap_ir) begin
      ir_sh_r <= jtag_pkg::OP_VALIDATE;
    end else if (tck_rise && st_sh_ir) begin
      ir_sh_r <= {tdi_f, ir_sh_r[jtag_pkg::IR_W-1:1]};
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ir_r <= jtag_pkg::IR_RESET;
    end else if (ce_in && st_tlr) begin
      ir_r <= jtag_pkg::IR_RESET;
    end else if (tck_fall && st_upd_ir) begin
      ir_r <= ir_sh_r;
    end
  end

  // Decode; reserved codes and VALIDATE fall through to plain bypass
  wire op_extest = (ir_r == jtag_pkg::OP_EXTEST);
  wire op_sample = (ir_r == jtag_pkg::OP_SAMPLE);
  wire op_idcode = (ir_r == jtag_pkg::OP_IDCODE);
  wire op_highz = (ir_r == jtag_pkg::OP_HIGHZ);
  wire op_clamp = (ir_r == jtag_pkg::OP_CLAMP);
  wire sel_bsr = op_extest | op_sample;
  wire sel_id = op_idcode;
  wire sel_byp = ~sel_bsr & ~sel_id;
  wire test_drive = op_extest | op_clamp;

  // Boundary shift stage and update latches
  logic [BSR_W-1:0] bsr_sh_r, bsr_cap;
  logic [BSR_W-1:N_IN] upd_r;  // Input cells have no update stage
  logic [N_BIDIR-1:0] bd_oe_eff;

  generate
    for (g = 0; g < N_IN; g++) begin : g_in
      assign bsr_cap[g] = pad_f[g];
    end
    for (g = 0; g < N_OUT; g++) begin : g_out
      assign bsr_cap[O_BASE + g] = core_out_in[g];
    end
    for (g = 0; g < N_BIDIR; g++) begin : g_bd
      assign bd_oe_eff[g] = op_extest ? upd_r[B_BASE + 2 * g + 1] : core_bd_oe_in[g];
      assign bsr_cap[B_BASE + 2 * g] =
        (bd_oe_eff[g] && !op_extest) ? core_bd_out_in[g] : pad_bd_f[g];
      assign bsr_cap[B_BASE + 2 * g + 1] = core_bd_oe_in[g];
    end
  endgenerate
  assign bsr_cap[OE_POS] = core_oe_in;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bsr_sh_r <= '0;
    end else if (tck_rise && sel_bsr && st_cap_dr) begin
      bsr_sh_r <= bsr_cap;
    end else if (tck_rise && sel_bsr && st_sh_dr) begin
      bsr_sh_r <= {tdi_f, bsr_sh_r[BSR_W-1:1]};
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      upd_r <= '0;
    end else if (tck_fall && sel_bsr && st_upd_dr) begin
      upd_r <= bsr_sh_r[BSR_W-1:N_IN];
    end
  end

  // Bypass and identification registers
  logic byp_r;
  logic [jtag_pkg::ID_W-1:0] id_sh_r;
  wire [jtag_pkg::ID_W-1:0] id_val = {ID_VER, ID_PART, ID_MANUF, jtag_pkg::ID_MARKER};

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      byp_r <= jtag_pkg::BYPASS_CAPTURE;
    end else if (tck_rise && sel_byp && st_cap_dr) begin
      byp_r <= jtag_pkg::BYPASS_CAPTURE;
    end else if (tck_rise && sel_byp && st_sh_dr) begin
      byp_r <= tdi_f;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      id_sh_r <= '0;
    end else if (tck_rise && sel_id && st_cap_dr) begin
      id_sh_r <= id_val;
    end else if (tck_rise && sel_id && st_sh_dr) begin
      id_sh_r <= {tdi_f, id_sh_r[jtag_pkg::ID_W-1:1]};
    end
  end

  // Serial output selection and falling-edge launch
  wire dr_bit = sel_bsr ? bsr_sh_r[0] : (sel_id ? id_sh_r[0] : byp_r);
  wire scan_bit = st_sh_ir ? ir_sh_r[0] : dr_bit;
  logic tdo_r, tdo_oe_r;

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tdo_r <= 1'h0;
      tdo_oe_r <= 1'h0;
    end else if (ce_in && st_tlr) begin
      tdo_oe_r <= 1'h0;
    end else if (tck_fall) begin
      tdo_r <= scan_bit;
      tdo_oe_r <= st_sh_dr | st_sh_ir;
    end
  end
  assign tdo_out = tdo_r;
  assign tdo_oe_out = tdo_oe_r;

  // Pin drive: core in normal use, update latches under EXTEST/CLAMP, off under HIGHZ
  wire [N_OUT-1:0] out_nxt = test_drive ? upd_r[O_BASE +: N_OUT] : core_out_in;
  wire oe_nxt = ~op_highz & (test_drive ? upd_r[OE_POS] : core_oe_in);
  logic [N_OUT-1:0] pad_out_r;
  logic pad_oe_r;
  logic [N_BIDIR-1:0] bd_out_nxt, bd_oe_nxt, pad_bd_out_r, pad_bd_oe_r;

  generate
    for (g = 0; g < N_BIDIR; g++) begin : g_bd_drv
      assign bd_out_nxt[g] = test_drive ? upd_r[B_BASE + 2 * g] : core_bd_out_in[g];
      assign bd_oe_nxt[g] = ~op_highz &
        (test_drive ? upd_r[B_BASE + 2 * g + 1] : core_bd_oe_in[g]);
    end
  endgenerate

  // One clock of delay keeps every pin straight from a flip-flop
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pad_out_r <= '0;
      pad_oe_r <= 1'h0;
      pad_bd_out_r <= '0;
      pad_bd_oe_r <= '0;
    end else if (ce_in) begin
      pad_out_r <= out_nxt;
      pad_oe_r <= oe_nxt;
      pad_bd_out_r <= bd_out_nxt;
      pad_bd_oe_r <= bd_oe_nxt;
    end
  end
  assign pad_out = pad_out_r;
  assign pad_oe_out = pad_oe_r;
  assign pad_bd_out = pad_bd_out_r;
  assign pad_bd_oe_out = pad_bd_oe_r;
  assign ir_out = ir_r;

endmodule : boundary_scan_tap

// *** hdl/jtag_pkg.sv ***
package jtag_pkg;

  // Instruction register
  localparam int IR_W = 6;
  localparam logic [5:0] OP_EXTEST = 6'h00;
  localparam logic [5:0] OP_SAMPLE = 6'h01;
  localparam logic [5:0] OP_IDCODE = 6'h02;
  localparam logic [5:0] OP_HIGHZ = 6'h03;
  localparam logic [5:0] OP_VALIDATE = 6'h2D;
  localparam logic [5:0] OP_CLAMP = 6'h3E;
  localparam logic [5:0] OP_BYPASS = 6'h3F;
  localparam logic [5:0] IR_RESET = OP_IDCODE;

  // Identification register layout
  localparam int ID_W = 32;
  localparam int ID_MANUF_LSB = 1;
  localparam int ID_PART_LSB = 12;
  localparam int ID_VER_LSB = 28;
  localparam logic ID_MARKER = 1'h1;

  // Pin input filter depth
  localparam int SYNC_STAGES = 3;
  localparam logic BYPASS_CAPTURE = 1'h0;

  // Test clock edges in the bench fall every few system clocks; this is a floor
  localparam int CLK_NS = 100;
  localparam int TCK_MIN_NS = 800;
  localparam int TCK_MIN_CYC = (TCK_MIN_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [3:0] {
    TLR = 4'h0,
    RTI = 4'h1,
    SEL_DR = 4'h3,
    CAP_DR = 4'h2,
    SHIFT_DR = 4'h6,
    EXIT1_DR = 4'h7,
    PAUSE_DR = 4'h5,
    EXIT2_DR = 4'h4,
    UPD_DR = 4'hC,
    SEL_IR = 4'hD,
    CAP_IR = 4'hF,
    SHIFT_IR = 4'hE,
    EXIT1_IR = 4'hA,
    PAUSE_IR = 4'hB,
    EXIT2_IR = 4'h9,
    UPD_IR = 4'h8
  } tap_state_e;

  typedef struct packed {
    logic trst_b;
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_s;

endpackage : jtag_pkg

// *** verif/jtag_asserts.sv ***
`timescale 1ns/100ps
module jtag_asserts #(
  parameter int N_OUT = 4,
  parameter int N_BIDIR = 4
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire jtag_pkg::tap_pins_s jtag_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_out,
  input wire logic [N_OUT-1:0] core_out_in,
  input wire logic core_oe_in,
  input wire logic [N_BIDIR-1:0] core_bd_oe_in,
  input wire logic [N_OUT-1:0] pad_out,
  input wire logic pad_oe_out,
  input wire logic [N_BIDIR-1:0] pad_bd_out,
  input wire logic [N_BIDIR-1:0] pad_bd_oe_out,
  input wire logic [5:0] ir_out
);
  wire drive_w = ir_out == jtag_pkg::OP_EXTEST || ir_out == jtag_pkg::OP_CLAMP;
  wire norm_w = !drive_w && ir_out != jtag_pkg::OP_HIGHZ;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Three cycles so the pin register has settled after a mode change
  sequence s_norm;
    norm_w [*3] ##0 $past(rst_b_in, 2);
  endsequence
  sequence s_highz;
    (ir_out == jtag_pkg::OP_HIGHZ) [*2];
  endsequence
  chk_ir_reset: assert property ($rose(rst_b_in) |-> ir_out == jtag_pkg::IR_RESET)
    else $error("instruction not identification after reset");
  chk_trst_idcode: assert property (!jtag_in.trst_b [*6] |-> ##1 ir_out == jtag_pkg::IR_RESET)
    else $error("test reset did not select identification");
  chk_pin_data: assert property (s_norm |-> pad_out == $past(core_out_in))
    else $error("pin data not following core");
  chk_pin_enable: assert property (s_norm |-> pad_oe_out == $past(core_oe_in))
    else $error("pin enable not following core");
  chk_bd_enable: assert property (s_norm |-> pad_bd_oe_out == $past(core_bd_oe_in))
    else $error("bidir enable not following core");
  chk_highz_off: assert property (s_highz |-> !pad_oe_out && pad_bd_oe_out == '0)
    else $error("enable active in float mode");
  chk_latch_hold: assert property (
    drive_w && $past(drive_w) && tdo_oe_out && $past(tdo_oe_out)
    |-> $stable(pad_out) && $stable(pad_bd_out))
    else $error("driven pins moved while shifting");
  chk_tdo_fall: assert property ($changed(tdo_out) || $changed(tdo_oe_out)
    |-> !$past(jtag_in.tck) && !$past(jtag_in.tck, 2))
    else $error("serial out moved outside test clock low phase");
  chk_ir_quiet: assert property ($changed(ir_out) |-> !tdo_oe_out && !jtag_in.tck)
    else $error("instruction changed while shifting");
endmodule : jtag_asserts

bind boundary_scan_tap jtag_asserts #(.N_OUT(N_OUT), .N_BIDIR(N_BIDIR)) u_jtag_asserts (
  .clk_in(clk_in), .rst_b_in(rst_b_in), .jtag_in(jtag_in), .tdo_out(tdo_out),
  .tdo_oe_out(tdo_oe_out), .core_out_in(core_out_in), .core_oe_in(core_oe_in),
  .core_bd_oe_in(core_bd_oe_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
  .pad_bd_out(pad_bd_out), .pad_bd_oe_out(pad_bd_oe_out), .ir_out(ir_out));

// *** verif/jtag_tester.sv ***
`timescale 1ns/100ps
module jtag_tester (
  // Clock
  input wire logic clk_in,
  // Test port
  output jtag_pkg::tap_pins_s jtag_out,
  input wire logic tdo_in,
  input wire logic tdo_oe_in
);
  // Pull-up levels, test clock parked low between frames
  initial jtag_out = 4'hB;
  // One test clock of 8 system clocks; caller enters just after a clock edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    jtag_out.tms <= tms;
    jtag_out.tdi <= tdi;
    repeat (5) @(posedge clk_in);
    tdo = tdo_oe_in ? tdo_in : 1'bz;
    jtag_out.tck <= 1'b1;
    repeat (3) @(posedge clk_in);
    jtag_out.tck <= 1'b0;
  endtask : step
  task automatic scan(input logic ir, input int n, input logic [63:0] din,
      output logic [63:0] dout);
    logic b;
    dout = '0;
    step(1'b1, 1'b1, b);
    if (ir)
      step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : scan
  task automatic tms_reset();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : tms_reset
endmodule : jtag_tester

// *** verif/test_boundary_scan_tap.sv ***
`timescale 1ns/100ps
module test_boundary_scan_tap;
  // Preload: outputs A, shared enable 1, bidir data 5, bidir enables C
  localparam logic [16:0] PRE = 17'h163A0;
  localparam logic [12:0] DRIVEN = 13'h18BA;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [3:0] core_out_in = 4'h3;
  logic core_oe_in = 1'b0;
  logic [3:0] core_bd_out_in = 4'h6;
  logic [3:0] core_bd_oe_in = 4'hA;
  logic [3:0] pad_in = 4'hB;
  logic [3:0] ext_bd = 4'h9;
  jtag_pkg::tap_pins_s jtag_w;
  logic tdo_out, tdo_oe_out, pad_oe_out;
  logic [3:0] pad_out, pad_bd_out, pad_bd_oe_out;
  logic [5:0] ir_out;
  logic [63:0] d;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  wire [3:0] pad_bd_in = (pad_bd_oe_out & pad_bd_out) | (~pad_bd_oe_out & ext_bd);
  wire [12:0] pins_w = {pad_bd_oe_out, pad_bd_out, pad_oe_out, pad_out};
  wire [12:0] core_w = {core_bd_oe_in, core_bd_out_in, core_oe_in, core_out_in};

  boundary_scan_tap u_boundary_scan_tap (.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(1'b1),
    .jtag_in(jtag_w), .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .core_out_in(core_out_in),
    .core_oe_in(core_oe_in), .core_bd_out_in(core_bd_out_in), .core_bd_oe_in(core_bd_oe_in),
    .pad_in(pad_in), .pad_bd_in(pad_bd_in), .pad_out(pad_out), .pad_oe_out(pad_oe_out),
    .pad_bd_out(pad_bd_out), .pad_bd_oe_out(pad_bd_oe_out), .ir_out(ir_out));
  jtag_tester u_jtag_tester (.clk_in(clk_in), .jtag_out(jtag_w), .tdo_in(tdo_out),
    .tdo_oe_in(tdo_oe_out));

  always #50 clk_in = ~clk_in;

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : check
  // Boundary chain capture as the pins stand now
  function automatic logic [16:0] cap(input logic ext);
    cap = {8'h00, core_oe_in, core_out_in, pad_in};
    for (int g = 0; g < 4; g++) begin
      cap[9+2*g] = (core_bd_oe_in[g] && !ext) ? core_bd_out_in[g] : pad_bd_in[g];
      cap[10+2*g] = core_bd_oe_in[g];
    end
  endfunction : cap
  task automatic load_ir(input logic [5:0] op);
    u_jtag_tester.scan(1'b1, 6, {58'h0, op}, d);
    check(d[5:0], jtag_pkg::OP_VALIDATE);
    check(ir_out, op);
  endtask : load_ir
  task automatic t_idcode();
    check(ir_out, jtag_pkg::IR_RESET);
    u_jtag_tester.scan(1'b0, 32, '1, d);
    check(d[31:0], {4'h1, 16'h1234, 11'h155, 1'b1});
    $display("idcode done");
  endtask : t_idcode
  task automatic t_sample();
    load_ir(jtag_pkg::OP_SAMPLE);
    u_jtag_tester.scan(1'b0, 17, {47'h0, PRE}, d);
    check(d[16:0], cap(1'b0));
    check(pins_w, core_w);
    $display("sample done");
  endtask : t_sample
  task automatic t_extest();
    load_ir(jtag_pkg::OP_EXTEST);
    check(pins_w, DRIVEN);
    u_jtag_tester.scan(1'b0, 17, {47'h0, PRE}, d);
    check(d[16:0], cap(1'b1));
    check(pins_w, DRIVEN);
    load_ir(jtag_pkg::OP_HIGHZ);
    check({pad_bd_oe_out, pad_oe_out}, 5'h00);
    $display("extest done");
  endtask : t_extest
  task automatic t_one_bit();
    logic [5:0] ops [4] = '{jtag_pkg::OP_CLAMP, jtag_pkg::OP_BYPASS, 6'h10, 6'h3D};
    foreach (ops[i]) begin
      load_ir(ops[i]);
      u_jtag_tester.scan(1'b0, 3, '1, d);
      check(d[2:0], 3'h6);
      check(pins_w, i == 0 ? DRIVEN : core_w);
    end
    $display("one bit done");
  endtask : t_one_bit
  task automatic t_resets();
    u_jtag_tester.tms_reset();
    check(ir_out, jtag_pkg::IR_RESET);
    load_ir(jtag_pkg::OP_BYPASS);
    u_jtag_tester.jtag_out.trst_b <= 1'b0;
    repeat (8) @(posedge clk_in);
    check(ir_out, jtag_pkg::IR_RESET);
    u_jtag_tester.jtag_out.trst_b <= 1'b1;
    $display("resets done");
  endtask : t_resets
  task automatic end_sim();
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    u_jtag_tester.tms_reset();
    t_idcode();
    t_sample();
    t_extest();
    t_one_bit();
    t_resets();
    end_sim();
  end
endmodule : test_boundary_scan_tap
